// File: dv/linear_array_scan_sequencer_test.sv
`timescale 1ns/10ps
`include "scan_seq_consts.vh"
module linear_array_scan_sequencer_test;
  localparam N = `PIXEL_COUNT;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  wire       startIn, sensorClk, outDrive, integReset, integrating;
  wire       frameValid, pixelStrobe, holdValid;
  integer    strobeCnt = 0;
  wire [7:0] pixelIdx;
  integer    numErrors = 0;
  integer    numChecks = 0;
  always #25 clk = ~clk;
  // Converter strobes seen so far
  always @(posedge clk) if (pixelStrobe) strobeCnt <= strobeCnt + 1;
  scan_host host (.clk(clk), .startIn(startIn), .sensorClk(sensorClk));
  linear_array_scan_sequencer dut (.clk(clk), .rst(rst), .startIn(startIn),
    .sensorClk(sensorClk), .pixelIdx(pixelIdx), .outDrive(outDrive),
    .integReset(integReset), .integrating(integrating), .holdValid(holdValid),
    .frameValid(frameValid), .pixelStrobe(pixelStrobe));
  task check(input [7:0] seen, input [7:0] want);
    begin
      numChecks = numChecks + 1;
      if (seen !== want) begin
        numErrors = numErrors + 1;
        $display("[ERR] %0t seen %0h want %0h", $time, seen, want);
      end
    end
  endtask
  task closeOut;
    begin
      if (numErrors == 0 && numChecks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Whole frame, n+1 clocks, then the charge transfer wait
  task tFrame(input [7:0] fv);
    integer k;
    integer base;
    begin
      base = strobeCnt;
      for (k = 1; k <= N + 1; k = k + 1) begin
        host.pulse(k == 1);
        check(pixelIdx, (k > N) ? 8'h00 : k[7:0]);
        check({7'h00, outDrive}, {7'h00, k <= N});
        if (k == 2) check({7'h00, frameValid}, fv);
        if (k == 2) check({7'h00, holdValid}, fv);
        if (k == 2) check({7'h00, integReset}, 8'h01);
        if (k == 40) check({7'h00, integrating}, 8'h01);
      end
      base = strobeCnt - base;
      check(base[7:0], N[7:0]);
      // Fixed spacing keeps integration in bounds
      repeat (`XFER_CYCLES) @(posedge clk);
    end
  endtask
  // Second start mid-frame restarts the scan at pixel one
  task tRestart;
    begin
      host.pulse(1'b1);
      repeat (39) host.pulse(1'b0);
      host.pulse(1'b1);
      check(pixelIdx, 8'h01);
      check({7'h00, integReset}, 8'h01);
      repeat (N) host.pulse(1'b0);
      check({7'h00, outDrive}, 8'h00);
      repeat (`XFER_CYCLES) @(posedge clk);
    end
  endtask
  // Clocks with no start leave the array idle
  task tIdle;
    begin
      repeat (3) host.pulse(1'b0);
      check(pixelIdx, 8'h00);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tFrame(8'h00);
    tFrame(8'h01);
    tRestart;
    tIdle;
    closeOut;
  end
  // Watchdog, several times the expected run
  initial begin
    #1000000;
    numErrors = numErrors + 1;
    closeOut;
  end
endmodule

// File: dv/scan_host.sv
`timescale 1ns/10ps
module scan_host (
  input  wire clk,       // System clock
  output reg  startIn,   // Start pin
  output reg  sensorClk  // Sensor clock, idles low
);
  initial {startIn, sensorClk} = 2'b00;
  // One sensor clock of 12 cycles, well under the rate cap
  task pulse(input st);
    begin
      @(posedge clk) startIn <= st;
      @(posedge clk) sensorClk <= 1'b1;
      repeat (6) @(posedge clk);
      {startIn, sensorClk} <= 2'b00; // Start spans one edge
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// File: dv/scan_seq_properties.sv
`timescale 1ns/10ps
module scan_seq_properties #(parameter PIXELS = 128, SETUP = 18) (
  input wire       clk, rst, outDrive, integReset, integrating, pixelStrobe,
  input wire [7:0] pixelIdx
);
  // Single domain, so one clocking and one disable serve all
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_last_hiz:
    assert property ($fell(outDrive) |-> $past(pixelIdx) == PIXELS)
    else $error("output released early");
  a_start_reset:
    assert property ($changed(pixelIdx) && pixelIdx == 8'h01 |-> integReset)
    else $error("scan began without integrator reset");
  a_step_strobe:
    assert property ($changed(pixelIdx) && pixelIdx != 8'h00 |-> pixelStrobe)
    else $error("pixel step without strobe");
  a_pixel_held:
    assert property ($changed(pixelIdx) |=> $stable(pixelIdx) [*2])
    else $error("pixel not held");
  a_setup_end:
    assert property ($fell(integReset) |-> integrating &&
      (pixelIdx == SETUP || pixelIdx == SETUP + 1))
    else $error("setup span wrong");
  a_strobe_single:
    assert property (pixelStrobe |=> !pixelStrobe)
    else $error("strobe longer than one cycle");
  a_idle_hiz:
    assert property (pixelIdx == 8'h00 |-> !outDrive)
    else $error("output driven while idle");
endmodule
bind linear_array_scan_sequencer scan_seq_properties #(.PIXELS(PIXELS),
  .SETUP(SETUP)) chk (.clk, .rst, .outDrive, .integReset, .integrating,
  .pixelStrobe, .pixelIdx);

// File: logic/edge_sync.v
`timescale 1ns/10ps
// Three-stage synchroniser with rise detection on agreeing stages 2 and 3
module edge_sync (
  input  wire clk,      // System clock
  input  wire rst,      // Async reset, active high
  input  wire din,      // Asynchronous pin level
  output reg  level,    // Filtered level
  output reg  rise      // One-cycle pulse on filtered rise
);
  reg s1Q;
  reg s2Q;
  reg s3Q;

  // Stage chain; first stage is read by the second only
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Q   <= 1'b0;
      s2Q   <= 1'b0;
      s3Q   <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      s1Q  <= din;
      s2Q  <= s1Q;
      s3Q  <= s2Q;
      rise <= 1'b0;
      // A change counts only once stages 2 and 3 agree
      if (s2Q == s3Q) begin
        rise  <= s3Q & ~level;
        level <= s3Q;
      end
    end
  end
endmodule

// File: logic/linear_array_scan_sequencer.v
`timescale 1ns/10ps
`include "scan_seq_consts.vh"
// Contract
// - Output goes high-impedance after clock rise n+1 following a start.
// - A cycle begins on a clock rise while start is high; the clock idles low.
// - Last exposure reads out one pixel per clock as the next integrates.
// - Each pixel value is held for a full clock period for the converter.
// - Integrators are held in reset for the first 18 clocks after a start.
module linear_array_scan_sequencer #(
  parameter PIXELS = `PIXEL_COUNT,   // Pixel count n
  parameter SETUP  = `SETUP_CLOCKS   // Integrator reset clocks
) (
  input  wire       clk,            // System clock, 20 MHz
  input  wire       rst,            // Async reset, active high
  input  wire       startIn,        // Start pulse pin
  input  wire       sensorClk,      // Sensor clock pin
  output reg  [7:0] pixelIdx,       // Pixel on output, 1..n, 0 idle
  output reg        outDrive,       // Analog output enabled (low = hi-Z)
  output reg        integReset,     // Integrators held in reset
  output reg        integrating,    // Integrators accumulating
  output reg        holdValid,      // Held frame exists
  output reg        frameValid,     // Readout is of a real exposure
  output reg        pixelStrobe     // Pulse when new pixel presented
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 2'b01;
  localparam ST_READ = 2'b10;

  wire       startLvl;     // Synced start level
  wire       startRise;    // Start captured by a clock rise
  wire       clkLvl;       // Synced sensor clock level
  wire       clkRise;      // One pulse per sensor clock rise
  reg  [1:0] stateQ;       // Scan state
  reg  [1:0] stateD;
  reg  [8:0] edgeCntQ;     // Rises since start, start edge is 1
  reg  [8:0] edgeCntD;
  reg        startSeenQ;   // Any start since reset
  reg        startSeenD;
  reg  [7:0] pixelIdxD;    // Next values of the output flops
  reg        outDriveD;
  reg        integResetD;
  reg        integratingD;
  reg        holdValidD;
  reg        frameValidD;
  reg        pixelStrobeD;
  wire       setupDone;    // Edge that opens integration
  wire       lastPixel;    // Edge that releases the output

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  edge_sync uStart (
    .clk   (clk),
    .rst   (rst),
    .din   (startIn),
    .level (startLvl),
    .rise  ()
  );
  edge_sync uClk (
    .clk   (clk),
    .rst   (rst),
    .din   (sensorClk),
    .level (clkLvl),
    .rise  (clkRise)
  );
  // Start is captured by a clock rise while start is high
  assign startRise = clkRise & startLvl;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Next edge count; nine bits never wrap within one scan
  function [8:0] nextEdge;
    input [8:0] cur;
    begin
      nextEdge = cur + 9'h001;
    end
  endfunction

  // True when the running edge count sits on a mark
  function atEdge;
    input [8:0] cur;
    input [8:0] mark;
    begin
      atEdge = (cur == mark);
    end
  endfunction

  // ----------------------------------------
  // Scan marks
  // ----------------------------------------
  // Marks are tested on the rise that follows the counted edge
  assign setupDone = atEdge(edgeCntQ, SETUP[8:0]);
  assign lastPixel = atEdge(edgeCntQ, PIXELS[8:0]);

  // ----------------------------------------
  // Readout sequencer, next state
  // ----------------------------------------
  // A start restarts the scan even mid-frame; the controller owns spacing
  always @* begin
    stateD       = stateQ;
    edgeCntD     = edgeCntQ;
    pixelIdxD    = pixelIdx;
    outDriveD    = outDrive;
    integResetD  = integReset;
    integratingD = integrating;
    // Strobe stands one cycle only
    pixelStrobeD = 1'b0;
    if (startRise) begin
      // Hold all pixels, present pixel 1
      stateD       = ST_READ;
      edgeCntD     = 9'h001;
      pixelIdxD    = 8'h01;
      outDriveD    = 1'b1;
      pixelStrobeD = 1'b1;
      integResetD  = 1'b1;
      integratingD = 1'b0;
    end else if (clkRise) begin
      // Rises outside a scan only hold the idle state
      case (stateQ)
        ST_READ: begin
          edgeCntD = nextEdge(edgeCntQ);
          // Integration opens on the 19th edge
          if (setupDone) begin
            integResetD  = 1'b0;
            integratingD = 1'b1;
          end
          if (lastPixel) begin
            // Edge n+1: output released
            stateD    = ST_IDLE;
            outDriveD = 1'b0;
            pixelIdxD = `IDX_RESET;
          end else begin
            // One pixel per clock, held a full period
            pixelIdxD    = pixelIdx + 8'h01;
            pixelStrobeD = 1'b1;
          end
        end
        ST_IDLE: begin
          // Rises with no start are ignored
          stateD = ST_IDLE;
        end
        default: begin
          stateD = ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Frame validity, next state
  // ----------------------------------------
  // Only a start may change these; clock rises leave them alone
  always @* begin
    startSeenD  = startSeenQ;
    holdValidD  = holdValid;
    frameValidD = frameValid;
    if (startRise) begin
      // First frame after power-up is indeterminate
      frameValidD = startSeenQ & integrating;
      holdValidD  = startSeenQ;
      startSeenD  = 1'b1;
    end
  end

  // ----------------------------------------
  // Readout sequencer, registers
  // ----------------------------------------
  // Every output is a flop, so the converter sees no decode glitches
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // Idle, output released, nothing integrating
      stateQ      <= ST_IDLE;
      edgeCntQ    <= 9'h000;
      pixelIdx    <= `IDX_RESET;
      outDrive    <= 1'b0;
      integReset  <= 1'b0;
      integrating <= 1'b0;
      pixelStrobe <= 1'b0;
    end else begin
      // Next values are taken as one set
      stateQ      <= stateD;
      edgeCntQ    <= edgeCntD;
      pixelIdx    <= pixelIdxD;
      outDrive    <= outDriveD;
      integReset  <= integResetD;
      integrating <= integratingD;
      pixelStrobe <= pixelStrobeD;
    end
  end

  // ----------------------------------------
  // Frame validity, registers
  // ----------------------------------------
  // Kept apart so the scan logic stays free of bookkeeping
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // No start seen, so no frame is trusted
      startSeenQ <= 1'b0;
      holdValid  <= 1'b0;
      frameValid <= 1'b0;
    end else begin
      // Changes only on a captured start
      startSeenQ <= startSeenD;
      holdValid  <= holdValidD;
      frameValid <= frameValidD;
    end
  end
endmodule

// File: shared/scan_seq_consts.vh
`ifndef SCAN_SEQ_CONSTS_VH
`define SCAN_SEQ_CONSTS_VH
// ----------------------------------------
// Array geometry and timing
// ----------------------------------------
`define PIXEL_COUNT      128
`define SETUP_CLOCKS     18
`define CLK_PERIOD_NS    50
`define XFER_TIME_NS     20000
`define XFER_CYCLES      ((`XFER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDX_RESET        8'h00
`endif
